// ==== core/fault_qualify_latch.sv ====
// Fault qualification, event counting and latch-off control.
// Function
// - Protection input trips when its comparator reports above 3 V.
// - Ignore the comparator for 1 us after each driver turn-off.
// - Count an assertion only if it stays high at least 600 ns.
// - Latch off after 4 successive validated events, one per cycle.
// - Latched: stop drive, clamp supply near 7 V until power cycling.
// - Release latch when hold current falls below 30 uA.
// - Input high in one off time for 4 consecutive clock cycles latches off.
// - Supply above 25.5 V stops pulses at once and latches.
// - In the C variant supply over-voltage recovers automatically.
`timescale 1ns/1ns
`default_nettype none
module fault_qualify_latch #(
  parameter int BLANK_CYCLES = fault_qualify_pkg::BLANK_CYCLES,
  parameter int MIN_HIGH_CYCLES = fault_qualify_pkg::MIN_HIGH_CYCLES,
  parameter int EVENTS_TO_LATCH = fault_qualify_pkg::EVENTS_TO_LATCH,
  parameter int OTP_CYCLES = fault_qualify_pkg::OTP_CYCLES,
  parameter bit C_VARIANT = 1'b0
) (
  // Clock and reset.
  input wire logic CLK,
  input wire logic SYS_RST,
  // Driver timing from the PWM core.
  input wire logic DRV_ON,
  // Comparator and sense inputs.
  input wire logic PROT_ABOVE_3V,
  input wire logic SUPPLY_ABOVE_25V5,
  input wire logic HOLD_CURRENT_LOW,
  // Outputs.
  output logic DRIVE_ENABLE,
  output logic SUPPLY_CLAMP,
  output logic LATCHED,
  output logic OVER_VOLTAGE_FAULT
);
  localparam int CW = fault_qualify_pkg::CNT_W;
  localparam int EW = fault_qualify_pkg::EVT_W;

  typedef enum logic [1:0] {ST_ON, ST_BLANK, ST_SAMPLE} phase_type;

  logic prot_s, ovp_s, hold_low_s;
  logic drv_on_d_r, drv_on_d_nxt;
  phase_type phase_r, phase_nxt;
  logic [CW-1:0] blank_cnt_r, blank_cnt_nxt;
  logic [CW-1:0] high_cnt_r, high_cnt_nxt;
  logic valid_seen_r, valid_seen_nxt;
  logic [EW-1:0] evt_cnt_r, evt_cnt_nxt;
  logic [EW-1:0] otp_cnt_r, otp_cnt_nxt;
  logic latched_r, latched_nxt;
  logic auto_ovp_r, auto_ovp_nxt;
  logic drive_en_r, drive_en_nxt;
  logic clamp_r, clamp_nxt;
  logic ovp_out_r, ovp_out_nxt;
  logic turn_off, cycle_end, high_valid;
  logic otp_trip, evt_valid, evt_empty;

  pin_sync3 u_sync_prot (
    .clk(CLK),
    .rst(SYS_RST),
    .din(PROT_ABOVE_3V),
    .dout(prot_s)
  );
  pin_sync3 u_sync_ovp (
    .clk(CLK),
    .rst(SYS_RST),
    .din(SUPPLY_ABOVE_25V5),
    .dout(ovp_s)
  );
  pin_sync3 u_sync_hold (
    .clk(CLK),
    .rst(SYS_RST),
    .din(HOLD_CURRENT_LOW),
    .dout(hold_low_s)
  );

  // Window logic tracks blanking, pulse width and the over-temperature run.
  always_comb begin
    turn_off = drv_on_d_r && !DRV_ON;
    cycle_end = !drv_on_d_r && DRV_ON;
    high_valid = (high_cnt_r >= CW'(MIN_HIGH_CYCLES - 1)) && prot_s;
    drv_on_d_nxt = DRV_ON;
    phase_nxt = phase_r;
    blank_cnt_nxt = blank_cnt_r;
    high_cnt_nxt = high_cnt_r;
    valid_seen_nxt = valid_seen_r;
    otp_cnt_nxt = otp_cnt_r;
    otp_trip = 1'b0;
    evt_valid = 1'b0;
    evt_empty = 1'b0;
    case (phase_r)
      ST_ON: begin
        if (turn_off) begin
          phase_nxt = ST_BLANK;
          blank_cnt_nxt = '0;
        end
      end
      ST_BLANK: begin
        if (DRV_ON) begin
          phase_nxt = ST_ON;
        end else if (blank_cnt_r >= CW'(BLANK_CYCLES - 1)) begin
          phase_nxt = ST_SAMPLE;
          high_cnt_nxt = '0;
          valid_seen_nxt = 1'b0;
          otp_cnt_nxt = '0;
        end else begin
          blank_cnt_nxt = blank_cnt_r + CW'(1);
        end
      end
      ST_SAMPLE: begin
        if (prot_s) begin
          if (high_cnt_r != {CW{1'b1}}) begin
            high_cnt_nxt = high_cnt_r + CW'(1);
          end
          if (otp_cnt_r != {EW{1'b1}}) begin
            otp_cnt_nxt = otp_cnt_r + EW'(1);
          end
        end else begin
          high_cnt_nxt = '0;
          otp_cnt_nxt = '0;
        end
        if (high_valid) begin
          valid_seen_nxt = 1'b1;
        end
        if (prot_s && otp_cnt_r >= EW'(OTP_CYCLES - 1)) begin
          otp_trip = 1'b1;
        end
        if (cycle_end) begin
          phase_nxt = ST_ON;
          evt_valid = valid_seen_r || high_valid;
          evt_empty = !(valid_seen_r || high_valid);
        end
      end
      default: phase_nxt = ST_ON;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      drv_on_d_r <= 1'b0;
      phase_r <= ST_ON;
      blank_cnt_r <= '0;
      high_cnt_r <= '0;
      valid_seen_r <= 1'b0;
      otp_cnt_r <= '0;
    end else begin
      drv_on_d_r <= drv_on_d_nxt;
      phase_r <= phase_nxt;
      blank_cnt_r <= blank_cnt_nxt;
      high_cnt_r <= high_cnt_nxt;
      valid_seen_r <= valid_seen_nxt;
      otp_cnt_r <= otp_cnt_nxt;
    end
  end

  // Latch logic counts events and holds the latch while hold current flows.
  always_comb begin
    evt_cnt_nxt = evt_cnt_r;
    latched_nxt = latched_r;
    auto_ovp_nxt = 1'b0;
    if (evt_valid) begin
      evt_cnt_nxt = evt_cnt_r + EW'(1);
      if (evt_cnt_r >= EW'(EVENTS_TO_LATCH - 1)) begin
        latched_nxt = 1'b1;
      end
    end else if (evt_empty) begin
      evt_cnt_nxt = '0;
    end
    if (otp_trip) begin
      latched_nxt = 1'b1;
    end
    if (ovp_s) begin
      if (C_VARIANT) begin
        auto_ovp_nxt = 1'b1;
      end else begin
        latched_nxt = 1'b1;
      end
    end
    if (hold_low_s) begin
      latched_nxt = 1'b0;
      evt_cnt_nxt = '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      evt_cnt_r <= '0;
      latched_r <= 1'b0;
      auto_ovp_r <= 1'b0;
    end else begin
      evt_cnt_r <= evt_cnt_nxt;
      latched_r <= latched_nxt;
      auto_ovp_r <= auto_ovp_nxt;
    end
  end

  // Output logic registers drive permission, clamp and the fault flag.
  always_comb begin
    drive_en_nxt = !latched_nxt && !auto_ovp_nxt && !ovp_s;
    clamp_nxt = latched_nxt;
    ovp_out_nxt = ovp_s;
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      drive_en_r <= 1'b0;
      clamp_r <= 1'b0;
      ovp_out_r <= 1'b0;
    end else begin
      drive_en_r <= drive_en_nxt;
      clamp_r <= clamp_nxt;
      ovp_out_r <= ovp_out_nxt;
    end
  end

  assign DRIVE_ENABLE = drive_en_r;
  assign SUPPLY_CLAMP = clamp_r;
  assign LATCHED = latched_r;
  assign OVER_VOLTAGE_FAULT = ovp_out_r;
endmodule
`default_nettype wire

// ==== core/fault_qualify_pkg.sv ====
// Constants shared by the fault qualification and latch-off logic.
`default_nettype none
package fault_qualify_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLANK_TIME_NS = 1000;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                (BLANK_TIME_NS / CLK_PERIOD_NS);
  localparam int MIN_HIGH_NS = 600;
  localparam int MIN_HIGH_CYCLES = (MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EVENTS_TO_LATCH = 4;
  localparam int OTP_CYCLES = 4;
  localparam int CNT_W = 8;
  localparam int EVT_W = 3;
endpackage
`default_nettype wire

// ==== core/pin_sync3.sv ====
// Three-stage input synchroniser; a change counts when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_r, s2_r, s3_r, out_r;
  logic s1_nxt, s2_nxt, s3_nxt, out_nxt;
  always_comb begin
    s1_nxt = din;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      out_r <= out_nxt;
    end
  end
  assign dout = out_r;
endmodule
`default_nettype wire

// ==== dv/fault_qualify_latch_checker.sv ====
// Port checks for the fault latch block.
`timescale 1ns/1ns
`default_nettype none
module fault_qualify_latch_checker #(parameter bit C_VARIANT = 1'b0) (
  // Watched ports.
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic DRV_ON,
  input wire logic SUPPLY_ABOVE_25V5,
  input wire logic HOLD_CURRENT_LOW,
  input wire logic DRIVE_ENABLE,
  input wire logic SUPPLY_CLAMP,
  input wire logic LATCHED,
  input wire logic OVER_VOLTAGE_FAULT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  property p_clamp; LATCHED == SUPPLY_CLAMP; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp off");
  property p_stop; LATCHED [*2] |-> !DRIVE_ENABLE; endproperty
  a_stop: assert property (p_stop) else $error("drive on");
  property p_keep; !HOLD_CURRENT_LOW [*8] ##0 $past(LATCHED, 4) |-> LATCHED; endproperty
  a_keep: assert property (p_keep) else $error("latch lost");
  property p_free; HOLD_CURRENT_LOW [*6] |-> !LATCHED; endproperty
  a_free: assert property (p_free) else $error("latch held");
  property p_ovf;
    $stable(SUPPLY_ABOVE_25V5) [*5] |-> OVER_VOLTAGE_FAULT == SUPPLY_ABOVE_25V5;
  endproperty
  a_ovf: assert property (p_ovf) else $error("ov flag");
  property p_ov; !HOLD_CURRENT_LOW [*5] ##0 OVER_VOLTAGE_FAULT && !C_VARIANT |-> ##[0:2] LATCHED;
  endproperty
  a_ov: assert property (p_ov) else $error("ov no latch");
  property p_cut; OVER_VOLTAGE_FAULT |-> ##[0:1] !DRIVE_ENABLE; endproperty
  a_cut: assert property (p_cut) else $error("ov drive");
  property p_blank; $fell(DRV_ON) && !OVER_VOLTAGE_FAULT |=> !$rose(LATCHED) [*3]; endproperty
  a_blank: assert property (p_blank) else $error("blank");
endmodule
bind fault_qualify_latch fault_qualify_latch_checker #(.C_VARIANT(C_VARIANT)) u_chk (
  .CLK, .SYS_RST, .DRV_ON, .SUPPLY_ABOVE_25V5, .HOLD_CURRENT_LOW,
  .DRIVE_ENABLE, .SUPPLY_CLAMP, .LATCHED, .OVER_VOLTAGE_FAULT);
`default_nettype wire

// ==== dv/fault_qualify_latch_test.sv ====
// Bench for the fault latch block.
`timescale 1ns/1ns
`default_nettype none
module fault_qualify_latch_test;
  logic clk = 0, rst = 1, drv = 1, ov = 0, hold = 0;
  logic prot, den, clamp, lat, ovf, den_c, lat_c;
  logic [5:0] outs;
  logic [7:0] st = 0, ln = 0;
  int n_errors = 0, checks = 0;
  localparam int sel_lat = 0;
  localparam int sel_den = 1;
  localparam int sel_clamp = 2;
  localparam int sel_ovf = 3;
  localparam int sel_lat_c = 4;
  localparam int sel_den_c = 5;
  always #5 clk = ~clk;
  assign outs = {den_c, lat_c, ovf, clamp, den, lat};
  sense_net_model u_net (.clk, .drv_on(drv), .st, .ln, .prot);
  fault_qualify_latch #(.BLANK_CYCLES(8), .MIN_HIGH_CYCLES(3)) u_dut (.CLK(clk), .SYS_RST(rst),
    .DRV_ON(drv), .PROT_ABOVE_3V(prot), .SUPPLY_ABOVE_25V5(ov), .HOLD_CURRENT_LOW(hold),
    .DRIVE_ENABLE(den), .SUPPLY_CLAMP(clamp), .LATCHED(lat), .OVER_VOLTAGE_FAULT(ovf));
  fault_qualify_latch #(.BLANK_CYCLES(8), .MIN_HIGH_CYCLES(3), .C_VARIANT(1'b1)) u_dut_c (
    .CLK(clk), .SYS_RST(rst), .DRV_ON(drv), .PROT_ABOVE_3V(prot), .SUPPLY_ABOVE_25V5(ov),
    .HOLD_CURRENT_LOW(hold), .DRIVE_ENABLE(den_c), .SUPPLY_CLAMP(), .LATCHED(lat_c),
    .OVER_VOLTAGE_FAULT());
  task automatic close_out;
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(int sel, logic exp);
    @(negedge clk);
    checks++;
    if (outs[sel] !== exp) begin
      n_errors++;
      $display("ERROR %0t output %0d got %b", $time, sel, outs[sel]);
    end
    @(posedge clk);
  endtask
  task automatic boot;
    rst <= 1;
    repeat (6) @(posedge clk);
    rst <= 0;
    hold <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic sw(logic [7:0] s, logic [7:0] l);
    st <= s;
    ln <= l;
    drv <= 0;
    repeat (20) @(posedge clk);
    drv <= 1;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_count;
    boot;
    repeat (3) sw(8'h0c, 8'h03);
    sw(8'h0c, 8'h00);
    repeat (3) sw(8'h0c, 8'h03);
    chk(sel_lat, 1'b0);
    sw(8'h0c, 8'h03);
    chk(sel_lat, 1'b1);
    chk(sel_clamp, 1'b1);
    chk(sel_den, 1'b0);
    hold <= 1;
    repeat (8) @(posedge clk);
    chk(sel_lat, 1'b0);
    chk(sel_den, 1'b1);
  endtask
  task automatic t_filter;
    boot;
    repeat (4) sw(8'h0c, 8'h02);
    repeat (4) sw(8'h00, 8'h03);
    chk(sel_lat, 1'b0);
  endtask
  task automatic t_otp;
    boot;
    sw(8'h0c, 8'h07);
    chk(sel_lat, 1'b1);
  endtask
  task automatic t_ov;
    boot;
    ov <= 1;
    repeat (6) @(posedge clk);
    chk(sel_den, 1'b0);
    chk(sel_lat, 1'b1);
    chk(sel_ovf, 1'b1);
    chk(sel_den_c, 1'b0);
    chk(sel_lat_c, 1'b0);
    ov <= 0;
    repeat (8) @(posedge clk);
    chk(sel_lat, 1'b1);
    chk(sel_ovf, 1'b0);
    chk(sel_den_c, 1'b1);
    boot;
    chk(sel_lat, 1'b0);
    chk(sel_den, 1'b1);
  endtask
  initial begin
    t_count;
    t_filter;
    t_otp;
    t_ov;
    close_out;
  end
endmodule
`default_nettype wire

// ==== dv/sense_net_model.sv ====
// Sense network model driving the protection comparator output.
`timescale 1ns/1ns
`default_nettype none
module sense_net_model (
  // Timing and pulse shape.
  input wire logic clk,
  input wire logic drv_on,
  input wire logic [7:0] st,
  input wire logic [7:0] ln,
  // Comparator output.
  output logic prot
);
  int t = 0;
  always @(posedge clk) begin
    t <= drv_on ? 0 : t + 1;
    prot <= !drv_on && t >= st && t < st + ln;
  end
endmodule
`default_nettype wire
